// file: hdl/crcc_defines.svh
/*
 * constants of the core register set: flag positions, reset values,
 * priority codes and stack frame size.
 * assumes nothing of its surroundings; included by bare name.
 */
`ifndef CRCC_DEFINES_SVH
`define CRCC_DEFINES_SVH

// condition code bit positions
`define CRCC_BIT_C        3'd0
`define CRCC_BIT_Z        3'd1
`define CRCC_BIT_N        3'd2
`define CRCC_BIT_I0       3'd3
`define CRCC_BIT_H        3'd4
`define CRCC_BIT_I1       3'd5

// fixed ones in the two top bits
`define CRCC_CC_FIXED     8'hc0

// reset values
`define CRCC_CC_RST       8'he8
`define CRCC_ACC_RST      8'h00
`define CRCC_IDX_RST      8'h00
`define CRCC_IP_RST       16'h0000

// priority bit pairs {upper, lower}
`define CRCC_PRIO_LVL0    2'b10
`define CRCC_PRIO_LVL1    2'b01
`define CRCC_PRIO_LVL2    2'b00
`define CRCC_PRIO_LVL3    2'b11

// bytes pushed by an interrupt
`define CRCC_IRQ_FRAME    3'd5

`endif

// file: hdl/crcc_pkg.sv
/*
 * types of the core register set: selectors, operations, request
 * carriers, register view and the context sequencer states.
 * assumes nothing of the defines header; every encoding is written out here.
 */
package crcc_pkg;

	typedef enum logic [2:0] {
		SEL_ACC = 3'h0,
		SEL_X   = 3'h1,
		SEL_Y   = 3'h2,
		SEL_IPL = 3'h3,
		SEL_IPH = 3'h4,
		SEL_CC  = 3'h5
	} crcc_sel_t;

	typedef enum logic [3:0] {
		OP_LD  = 4'h0,
		OP_ADD = 4'h1,
		OP_ADC = 4'h2,
		OP_SUB = 4'h3,
		OP_SBC = 4'h4,
		OP_AND = 4'h5,
		OP_OR  = 4'h6,
		OP_XOR = 4'h7,
		OP_SLL = 4'h8,
		OP_SRL = 4'h9,
		OP_RLC = 4'ha,
		OP_RRC = 4'hb
	} crcc_op_t;

	typedef enum logic [2:0] {
		BR_HALF_CARRY = 3'h0,
		BR_NO_HALF    = 3'h1,
		BR_MINUS      = 3'h2,
		BR_PLUS       = 3'h3,
		BR_EQUAL      = 3'h4,
		BR_NOT_EQUAL  = 3'h5,
		BR_CARRY      = 3'h6,
		BR_NO_CARRY   = 3'h7
	} crcc_br_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_S_IPL = 4'b0001,
		ST_S_IPH = 4'b0011,
		ST_S_X   = 4'b0010,
		ST_S_ACC = 4'b0110,
		ST_S_CC  = 4'b0111,
		ST_R_CC  = 4'b0101,
		ST_R_ACC = 4'b0100,
		ST_R_X   = 4'b1100,
		ST_R_IPH = 4'b1101,
		ST_R_IPL = 4'b1111,
		ST_R_FIN = 4'b1110
	} crcc_state_t;

	typedef struct packed {
		logic       valid;
		crcc_op_t   op;
		crcc_sel_t  dst;
		logic       flags_only;
		logic [7:0] operand;
	} crcc_alu_req_t;

	typedef struct packed {
		logic       valid;
		crcc_sel_t  sel;
		logic [7:0] data;
	} crcc_wr_req_t;

	typedef struct packed {
		logic       set_carry_instr;
		logic       clear_carry_instr;
		logic       bit_test;
		logic       bit_test_val;
		logic       bit_wr;
		logic [2:0] bit_idx;
		logic       bit_val;
		logic       enable_irq_instr;
		logic       disable_irq_instr;
		logic       halt_instr;
		logic       wait_for_irq_instr;
	} crcc_cc_ctl_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] idx_x;
		logic [7:0] idx_y;
		logic [7:0] instr_pointer_high;
		logic [7:0] instr_pointer_low;
		logic [7:0] condition_code_flags;
	} crcc_view_t;

endpackage

// file: hdl/crcc_flag_unit.sv
/*
 * arithmetic and shift unit of the core: result plus half carry and
 * carry for one operation. purely combinational.
 * assumes the caller applies the result and the flag updates.
 */
`timescale 1ns/1ps

module crcc_flag_unit (
	input  wire crcc_pkg::crcc_op_t op,
	input  wire logic [7:0]         opa,
	input  wire logic [7:0]         opb,
	input  wire logic               cin,
	output logic [7:0]              res,
	output logic                    half,
	output logic                    carry,
	output logic                    upd_h,
	output logic                    upd_c
);

	logic [8:0] sum;
	logic [4:0] nib;
	logic       ci;

	always_comb begin
		ci    = (op == crcc_pkg::OP_ADC || op == crcc_pkg::OP_SBC) ? cin : 1'b0;
		sum   = 9'h000;
		nib   = 5'h00;
		res   = opb;
		half  = 1'b0;
		carry = 1'b0;
		upd_h = 1'b0;
		upd_c = 1'b0;
		unique case (op)
			crcc_pkg::OP_ADD, crcc_pkg::OP_ADC: begin
				sum   = {1'b0, opa} + {1'b0, opb} + {8'h00, ci};
				nib   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
				res   = sum[7:0];
				half  = nib[4]; // RULE_06
				carry = sum[8]; // RULE_09
				upd_h = 1'b1;
				upd_c = 1'b1;
			end
			crcc_pkg::OP_SUB, crcc_pkg::OP_SBC: begin
				sum   = {1'b0, opa} - {1'b0, opb} - {8'h00, ci};
				res   = sum[7:0];
				carry = sum[8]; // RULE_09
				upd_c = 1'b1;
			end
			crcc_pkg::OP_AND: res = opa & opb;
			crcc_pkg::OP_OR:  res = opa | opb;
			crcc_pkg::OP_XOR: res = opa ^ opb;
			crcc_pkg::OP_SLL: begin
				res   = {opa[6:0], 1'b0};
				carry = opa[7]; // RULE_10
				upd_c = 1'b1;
			end
			crcc_pkg::OP_SRL: begin
				res   = {1'b0, opa[7:1]};
				carry = opa[0]; // RULE_10
				upd_c = 1'b1;
			end
			crcc_pkg::OP_RLC: begin
				res   = {opa[6:0], cin};
				carry = opa[7]; // RULE_10
				upd_c = 1'b1;
			end
			crcc_pkg::OP_RRC: begin
				res   = {cin, opa[7:1]};
				carry = opa[0]; // RULE_10
				upd_c = 1'b1;
			end
			default: res = opb;
		endcase
	end

endmodule // crcc_flag_unit

// file: hdl/crcc_core_regs.sv
/*
 * architectural register set of the 8-bit core: accumulator, two index
 * registers, instruction pointer, condition code flags, branch test and
 * the interrupt context save/restore sequencer.
 * assumes the decoder holds off requests while busy is high, and a stack
 * memory that returns popped data the cycle after stk_pop.
 */
`timescale 1ns/1ps
`include "crcc_defines.svh"

////////////////////////////////////////////////////////////////////////
// How it works
// [RULE_01] one 8-bit accumulator for operands and results
// [RULE_02] two 8-bit index registers for addresses or data
// [RULE_03] context save and restore never touch second index
// [RULE_04] 16-bit instruction pointer from low and high bytes
// [RULE_05] registers reached only by dedicated ports, no address
// [RULE_06] half carry from bit 3 on add/adc
// [RULE_07] negative flag copies result bit 7
// [RULE_08] zero flag set when result is zero
// [RULE_09] carry flag marks arithmetic overflow or borrow
// [RULE_10] carry forced by instructions, bit test, shifts, rotates
// [RULE_11] flags select taken or not taken branches
// [RULE_12] bits 5 and 3 encode priority level
// [RULE_13] interrupt entry loads priority from software priority regs
// [RULE_14] priority changed by enable, disable, return, halt, wait, pop
// [RULE_15] whole flag register pushed and popped
// [RULE_16] each flag bit testable and writable alone
// [RULE_17] interrupt pushes low pointer byte first, five bytes
// [RULE_18] flag bits 7 and 6 read one, ignore writes
module crcc_core_regs (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire crcc_pkg::crcc_alu_req_t alu_req,
	input  wire crcc_pkg::crcc_wr_req_t  wr_req,
	input  wire crcc_pkg::crcc_cc_ctl_t  cc_ctl,
	input  wire logic                  ip_inc,
	input  wire logic                  ip_load,
	input  wire logic [15:0]           ip_addr,
	input  wire logic                  irq_entry,
	input  wire logic [1:0]            software_priority_regs,
	input  wire logic [15:0]           irq_vector,
	input  wire logic                  irq_return_instr,
	input  wire crcc_pkg::crcc_br_t    branch_cond,
	input  wire logic [7:0]            stk_rdata,
	output logic                       stk_push,
	output logic [7:0]                 stk_wdata,
	output logic                       stk_pop,
	output logic                       busy,
	output logic                       branch_taken,
	output logic [1:0]                 prio_level,
	output logic                       irq_disabled,
	output crcc_pkg::crcc_view_t       regs
);

	////////////////////////////////////////////////////////////////////
	// state

	crcc_pkg::crcc_state_t state_ff;
	crcc_pkg::crcc_state_t nxt_state;
	logic [7:0]            acc_ff;
	logic [7:0]            idx_x_ff;
	logic [7:0]            idx_y_ff;
	logic [15:0]           ip_ff;
	logic [7:0]            cc_ff;
	logic [7:0]            nxt_cc;
	logic [1:0]            lvl_ff;
	logic [15:0]           vec_ff;
	logic                  push_ff;
	logic                  pop_ff;
	logic [7:0]            wdata_ff;
	logic                  idle;
	logic                  go;
	logic                  alu_fire;
	logic                  alu_wb;
	logic [7:0]            opa;
	logic [7:0]            res;
	logic                  half;
	logic                  carry;
	logic                  upd_h;
	logic                  upd_c;

	assign idle = (state_ff == crcc_pkg::ST_IDLE);
	// entry and return win over any instruction in the same cycle
	assign go       = idle && !irq_entry && !irq_return_instr;
	assign alu_fire = go && alu_req.valid;
	assign alu_wb   = alu_fire && !alu_req.flags_only;
	assign busy     = !idle;

	////////////////////////////////////////////////////////////////////
	// operand source and arithmetic

	always_comb begin
		unique case (alu_req.dst)
			crcc_pkg::SEL_X:   opa = idx_x_ff;
			crcc_pkg::SEL_Y:   opa = idx_y_ff;
			crcc_pkg::SEL_IPL: opa = ip_ff[7:0];
			crcc_pkg::SEL_IPH: opa = ip_ff[15:8];
			crcc_pkg::SEL_CC:  opa = cc_ff;
			default:           opa = acc_ff;
		endcase
	end

	crcc_flag_unit u_flag (
		.op    (alu_req.op),
		.opa   (opa),
		.opb   (alu_req.operand),
		.cin   (cc_ff[`CRCC_BIT_C]),
		.res   (res),
		.half  (half),
		.carry (carry),
		.upd_h (upd_h),
		.upd_c (upd_c)
	);

	////////////////////////////////////////////////////////////////////
	// context sequencer

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			crcc_pkg::ST_IDLE: begin
				if (irq_entry)
					nxt_state = crcc_pkg::ST_S_IPL;
				else if (irq_return_instr)
					nxt_state = crcc_pkg::ST_R_CC;
			end
			crcc_pkg::ST_S_IPL: nxt_state = crcc_pkg::ST_S_IPH; // RULE_17
			crcc_pkg::ST_S_IPH: nxt_state = crcc_pkg::ST_S_X;
			crcc_pkg::ST_S_X:   nxt_state = crcc_pkg::ST_S_ACC;
			crcc_pkg::ST_S_ACC: nxt_state = crcc_pkg::ST_S_CC;
			crcc_pkg::ST_S_CC:  nxt_state = crcc_pkg::ST_IDLE;
			crcc_pkg::ST_R_CC:  nxt_state = crcc_pkg::ST_R_ACC;
			crcc_pkg::ST_R_ACC: nxt_state = crcc_pkg::ST_R_X;
			crcc_pkg::ST_R_X:   nxt_state = crcc_pkg::ST_R_IPH;
			crcc_pkg::ST_R_IPH: nxt_state = crcc_pkg::ST_R_IPL;
			crcc_pkg::ST_R_IPL: nxt_state = crcc_pkg::ST_R_FIN;
			crcc_pkg::ST_R_FIN: nxt_state = crcc_pkg::ST_IDLE;
			default:            nxt_state = crcc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			state_ff <= crcc_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// priority and vector are caught at entry so a change on the
	// controller side during the save cannot tear them
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_ff <= `CRCC_PRIO_LVL3;
			vec_ff <= `CRCC_IP_RST;
		end else if (idle && irq_entry) begin
			lvl_ff <= software_priority_regs; // RULE_13
			vec_ff <= irq_vector;
		end
	end

	// stack strobes and data are registered one state ahead; the
	// second index register is never part of the frame
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			push_ff  <= 1'b0;
			pop_ff   <= 1'b0;
			wdata_ff <= 8'h00;
		end else begin
			push_ff <= 1'b0;
			pop_ff  <= 1'b0;
			unique case (nxt_state)
				crcc_pkg::ST_S_IPL: begin
					push_ff  <= 1'b1;
					wdata_ff <= ip_ff[7:0]; // RULE_17
				end
				crcc_pkg::ST_S_IPH: begin
					push_ff  <= 1'b1;
					wdata_ff <= ip_ff[15:8];
				end
				crcc_pkg::ST_S_X: begin
					push_ff  <= 1'b1;
					wdata_ff <= idx_x_ff; // RULE_03
				end
				crcc_pkg::ST_S_ACC: begin
					push_ff  <= 1'b1;
					wdata_ff <= acc_ff;
				end
				crcc_pkg::ST_S_CC: begin
					push_ff  <= 1'b1;
					wdata_ff <= cc_ff; // RULE_15
				end
				crcc_pkg::ST_R_CC, crcc_pkg::ST_R_ACC, crcc_pkg::ST_R_X,
				crcc_pkg::ST_R_IPH, crcc_pkg::ST_R_IPL:
					pop_ff <= 1'b1;
				default: ;
			endcase
		end
	end

	assign stk_push  = push_ff;
	assign stk_pop   = pop_ff;
	assign stk_wdata = wdata_ff;

	////////////////////////////////////////////////////////////////////
	// accumulator and index registers

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			acc_ff <= `CRCC_ACC_RST;
		else if (state_ff == crcc_pkg::ST_R_X)
			acc_ff <= stk_rdata;
		else if (alu_wb && alu_req.dst == crcc_pkg::SEL_ACC)
			acc_ff <= res; // RULE_01
		else if (go && wr_req.valid && wr_req.sel == crcc_pkg::SEL_ACC)
			acc_ff <= wr_req.data;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			idx_x_ff <= `CRCC_IDX_RST;
		else if (state_ff == crcc_pkg::ST_R_IPH)
			idx_x_ff <= stk_rdata;
		else if (alu_wb && alu_req.dst == crcc_pkg::SEL_X)
			idx_x_ff <= res; // RULE_02
		else if (go && wr_req.valid && wr_req.sel == crcc_pkg::SEL_X)
			idx_x_ff <= wr_req.data;
	end

	// only instructions reach this one, never the context sequencer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			idx_y_ff <= `CRCC_IDX_RST;
		else if (alu_wb && alu_req.dst == crcc_pkg::SEL_Y)
			idx_y_ff <= res; // RULE_03
		else if (go && wr_req.valid && wr_req.sel == crcc_pkg::SEL_Y)
			idx_y_ff <= wr_req.data; // RULE_02
	end

	////////////////////////////////////////////////////////////////////
	// instruction pointer

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			ip_ff <= `CRCC_IP_RST;
		else if (state_ff == crcc_pkg::ST_S_CC)
			ip_ff <= vec_ff;
		else if (state_ff == crcc_pkg::ST_R_IPL)
			ip_ff[15:8] <= stk_rdata; // RULE_04
		else if (state_ff == crcc_pkg::ST_R_FIN)
			ip_ff[7:0] <= stk_rdata;
		else if (go && ip_load)
			ip_ff <= ip_addr; // RULE_04
		else if (alu_wb && alu_req.dst == crcc_pkg::SEL_IPL)
			ip_ff[7:0] <= res;
		else if (alu_wb && alu_req.dst == crcc_pkg::SEL_IPH)
			ip_ff[15:8] <= res;
		else if (go && wr_req.valid && wr_req.sel == crcc_pkg::SEL_IPL)
			ip_ff[7:0] <= wr_req.data;
		else if (go && wr_req.valid && wr_req.sel == crcc_pkg::SEL_IPH)
			ip_ff[15:8] <= wr_req.data;
		else if (go && ip_inc)
			ip_ff <= ip_ff + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////
	// condition code flags

	// later lines win within one cycle: whole write, then alu flags,
	// then carry and bit instructions, then priority instructions
	always_comb begin
		nxt_cc = cc_ff;
		if (state_ff == crcc_pkg::ST_R_ACC) begin
			nxt_cc = stk_rdata; // RULE_14
		end else if (state_ff == crcc_pkg::ST_S_CC) begin
			{nxt_cc[`CRCC_BIT_I1], nxt_cc[`CRCC_BIT_I0]} = lvl_ff; // RULE_13
		end else if (go) begin
			if (wr_req.valid && wr_req.sel == crcc_pkg::SEL_CC)
				nxt_cc = wr_req.data; // RULE_15
			if (alu_fire) begin
				nxt_cc[`CRCC_BIT_N] = res[7]; // RULE_07
				nxt_cc[`CRCC_BIT_Z] = (res == 8'h00); // RULE_08
				if (upd_h)
					nxt_cc[`CRCC_BIT_H] = half; // RULE_06
				if (upd_c)
					nxt_cc[`CRCC_BIT_C] = carry; // RULE_09
				if (alu_wb && alu_req.dst == crcc_pkg::SEL_CC)
					nxt_cc = res;
			end
			if (cc_ctl.set_carry_instr)
				nxt_cc[`CRCC_BIT_C] = 1'b1; // RULE_10
			if (cc_ctl.clear_carry_instr)
				nxt_cc[`CRCC_BIT_C] = 1'b0; // RULE_10
			if (cc_ctl.bit_test)
				nxt_cc[`CRCC_BIT_C] = cc_ctl.bit_test_val; // RULE_10
			if (cc_ctl.bit_wr)
				nxt_cc[cc_ctl.bit_idx] = cc_ctl.bit_val; // RULE_16
			if (cc_ctl.enable_irq_instr || cc_ctl.halt_instr || cc_ctl.wait_for_irq_instr)
				{nxt_cc[`CRCC_BIT_I1], nxt_cc[`CRCC_BIT_I0]} = `CRCC_PRIO_LVL0; // RULE_14
			if (cc_ctl.disable_irq_instr)
				{nxt_cc[`CRCC_BIT_I1], nxt_cc[`CRCC_BIT_I0]} = `CRCC_PRIO_LVL3; // RULE_14
		end
		nxt_cc = nxt_cc | `CRCC_CC_FIXED; // RULE_18
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cc_ff <= `CRCC_CC_RST;
		else
			cc_ff <= nxt_cc;
	end

	////////////////////////////////////////////////////////////////////
	// branch test and priority decode

	always_comb begin
		unique case (branch_cond)
			crcc_pkg::BR_HALF_CARRY: branch_taken = cc_ff[`CRCC_BIT_H]; // RULE_11
			crcc_pkg::BR_NO_HALF:    branch_taken = !cc_ff[`CRCC_BIT_H];
			crcc_pkg::BR_MINUS:      branch_taken = cc_ff[`CRCC_BIT_N];
			crcc_pkg::BR_PLUS:       branch_taken = !cc_ff[`CRCC_BIT_N];
			crcc_pkg::BR_EQUAL:      branch_taken = cc_ff[`CRCC_BIT_Z];
			crcc_pkg::BR_NOT_EQUAL:  branch_taken = !cc_ff[`CRCC_BIT_Z];
			crcc_pkg::BR_CARRY:      branch_taken = cc_ff[`CRCC_BIT_C];
			crcc_pkg::BR_NO_CARRY:   branch_taken = !cc_ff[`CRCC_BIT_C];
		endcase
	end

	always_comb begin
		unique case ({cc_ff[`CRCC_BIT_I1], cc_ff[`CRCC_BIT_I0]})
			`CRCC_PRIO_LVL0: prio_level = 2'h0; // RULE_12
			`CRCC_PRIO_LVL1: prio_level = 2'h1;
			`CRCC_PRIO_LVL2: prio_level = 2'h2;
			`CRCC_PRIO_LVL3: prio_level = 2'h3;
		endcase
	end

	assign irq_disabled = (prio_level == 2'h3); // RULE_12

	////////////////////////////////////////////////////////////////////
	// register view, no address decode anywhere

	assign regs = {acc_ff, idx_x_ff, idx_y_ff, ip_ff[15:8], ip_ff[7:0], cc_ff}; // RULE_05

endmodule // crcc_core_regs

// file: test/crcc_core_regs_assertions.sv
/* port checker of the core register set.
   assumes it is bound to crcc_core_regs. */
`timescale 1ns/1ps
module crcc_core_regs_assertions (
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire crcc_pkg::crcc_alu_req_t alu_req,
	input wire crcc_pkg::crcc_cc_ctl_t  cc_ctl,
	input wire logic                    irq_entry,
	input wire logic                    irq_return_instr,
	input wire crcc_pkg::crcc_br_t      branch_cond,
	input wire logic                    stk_push,
	input wire logic [7:0]              stk_wdata,
	input wire logic                    stk_pop,
	input wire logic                    busy,
	input wire logic                    branch_taken,
	input wire logic [1:0]              prio_level,
	input wire logic                    irq_disabled,
	input wire crcc_pkg::crcc_view_t    regs
);
	logic [7:0] cc;
	logic [3:0] fl;
	logic       go;
	logic       alu_acc;
	logic [4:0] lo_sum;
	logic [7:0] and_res;
	assign cc = regs.condition_code_flags;
	assign fl = {cc[0], cc[1], cc[2], cc[4]};
	assign go = !busy && !irq_entry && !irq_return_instr;
	// a bit write in the same cycle would win over the alu flags
	assign alu_acc = go && alu_req.valid && alu_req.dst == crcc_pkg::SEL_ACC && !cc_ctl.bit_wr;
	assign lo_sum = {1'b0, regs.acc[3:0]} + {1'b0, alu_req.operand[3:0]};
	assign and_res = regs.acc & alu_req.operand;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	sequence s_five_push;
		stk_push [*5] ##1 !stk_push;
	endsequence
	sequence s_five_pop;
		stk_pop [*5] ##1 (!stk_pop && busy) ##1 !busy;
	endsequence
	a_top_ones: assert property (cc[7:6] == 2'b11) else $error("cc top bits not one");
	a_prio_code: assert property (prio_level == {~(cc[5] ^ cc[3]), cc[3]}) else $error("bad level");
	a_irq_off: assert property (irq_disabled == (cc[5] && cc[3])) else $error("bad disable");
	a_branch_sel: assert property (branch_taken == (fl[branch_cond[2:1]] ^ branch_cond[0]))
		else $error("bad branch decision");
	a_half_carry: assert property (alu_acc && alu_req.op == crcc_pkg::OP_ADD |=> cc[4] == $past(lo_sum[4]))
		else $error("bad half carry");
	a_logic_nz: assert property (alu_acc && alu_req.op == crcc_pkg::OP_AND
		|=> cc[2:1] == $past({and_res[7], and_res == 8'h00})) else $error("bad n or z");
	a_set_carry: assert property (go && cc_ctl.set_carry_instr && !cc_ctl.clear_carry_instr
		&& !cc_ctl.bit_test && !cc_ctl.bit_wr |=> cc[0]) else $error("carry not set");
	a_save_frame: assert property (!busy && irq_entry |=> s_five_push) else $error("bad push count");
	a_low_first: assert property (!busy && irq_entry |=> stk_wdata == $past(regs.instr_pointer_low))
		else $error("first push not pointer low");
	a_restore_frame: assert property (!busy && !irq_entry && irq_return_instr |=> s_five_pop)
		else $error("bad pop count");
	a_y_kept: assert property (busy |-> $stable(regs.idx_y)) else $error("second index moved");
endmodule // crcc_core_regs_assertions

bind crcc_core_regs crcc_core_regs_assertions u_chk (.mclk, .rst_n, .alu_req, .cc_ctl, .irq_entry,
	.irq_return_instr, .branch_cond, .stk_push, .stk_wdata, .stk_pop, .busy, .branch_taken, .prio_level,
	.irq_disabled, .regs);

// file: test/crcc_stack_model.sv
/* stack memory beside the core: stores pushed bytes, returns popped ones.
   assumes pops answer in the cycle after stk_pop. */
`timescale 1ns/1ps
module crcc_stack_model (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        stk_push,
	input wire logic        stk_pop,
	input wire logic [7:0]  stk_wdata,
	output logic [7:0]      stk_rdata
);
	logic [7:0] mem_ff [16];
	logic [3:0] sp_ff;
	always_ff @(posedge mclk) begin
		if (stk_push) begin
			mem_ff[sp_ff] <= stk_wdata;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sp_ff <= 4'h0;
		end else if (stk_push) begin
			sp_ff <= sp_ff + 4'h1;
		end else if (stk_pop) begin
			sp_ff <= sp_ff - 4'h1;
		end
	end
	// outside the answer cycle the byte flips, so a late sample never looks right
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stk_rdata <= 8'h00;
		end else begin
			stk_rdata <= stk_pop ? mem_ff[sp_ff - 4'h1] : ~stk_rdata;
		end
	end
endmodule // crcc_stack_model

// file: test/tb_top.sv
/* testbench of the core register set: request tasks and call sequences.
   assumes the stack model on the stack strobes. */
`timescale 1ns/1ps
module tb_top;
	logic                    mclk, rst_n, ip_inc, ip_load, irq_entry, irq_return_instr;
	logic                    stk_push, stk_pop, busy, branch_taken, irq_disabled;
	logic [15:0]             ip_addr, irq_vector;
	logic [1:0]              software_priority_regs, prio_level;
	logic [7:0]              stk_rdata, stk_wdata, cc;
	crcc_pkg::crcc_alu_req_t alu_req;
	crcc_pkg::crcc_wr_req_t  wr_req;
	crcc_pkg::crcc_cc_ctl_t  cc_ctl;
	crcc_pkg::crcc_br_t      branch_cond;
	crcc_pkg::crcc_view_t    regs;
	int                      n_errors = 0, num_checks = 0, cyc = 0, n;
	logic [7:0]              pl [4] = '{8'h20, 8'h08, 8'h00, 8'h28};
	logic [12:0] cv [10] = '{13'h1000, 13'h0800, 13'h0600, 13'h0190, 13'h0004, 13'h0008, 13'h0004,
		13'h0002, 13'h0004, 13'h0001};
	logic [7:0] ev [10] = '{8'hc1, 8'hc0, 8'hc1, 8'hd1, 8'hf9, 8'hf1, 8'hf9, 8'hf1, 8'hf9, 8'hf1};
	logic [7:0] ex [8] = '{8'h34, 8'h12, 8'h3c, 8'h5a, 8'hc0, 8'h00, 8'h00, 8'h00};
	assign cc = regs.condition_code_flags;
	initial mclk = 1'b0;
	always #2 mclk = ~mclk;
	crcc_core_regs dut (.mclk, .rst_n, .alu_req, .wr_req, .cc_ctl, .ip_inc, .ip_load, .ip_addr, .irq_entry,
		.software_priority_regs, .irq_vector, .irq_return_instr, .branch_cond, .stk_rdata, .stk_push,
		.stk_wdata, .stk_pop, .busy, .branch_taken, .prio_level, .irq_disabled, .regs);
	crcc_stack_model u_stk (.mclk, .rst_n, .stk_push, .stk_pop, .stk_wdata, .stk_rdata);
	////////////////////////////////////////
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(crcc_pkg::crcc_sel_t s, logic [7:0] d);
		wr_req = '{1'b1, s, d};
		tick();
		wr_req.valid = 1'b0;
		tick();
	endtask
	task automatic ctl(logic [12:0] c);
		cc_ctl = c;
		tick();
		cc_ctl = '0;
		tick();
	endtask
	task automatic alu(crcc_pkg::crcc_op_t o, logic [7:0] a, b, logic ci, logic [7:0] er, logic [3:0] ef, m);
		wr(crcc_pkg::SEL_CC, {7'h60, ci});
		wr(crcc_pkg::SEL_ACC, a);
		alu_req = '{1'b1, o, crcc_pkg::SEL_ACC, 1'b0, b};
		tick();
		alu_req.valid = 1'b0;
		tick();
		chk("alu result", er, regs.acc);
		chk("alu flags", {4'h0, ef & m}, {4'h0, m & {cc[4], cc[2:0]}});
	endtask
	task automatic wait_idle();
		repeat (20) if (busy !== 1'b0) tick();
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			$display("[FAIL] run length expected 2000 seen %0d", cyc);
			report_and_stop();
		end
	end
	////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		{ip_inc, ip_load, irq_entry, irq_return_instr} = 4'h0;
		{ip_addr, irq_vector} = 32'h0000_0000;
		software_priority_regs = 2'b00;
		alu_req = '0;
		wr_req = '0;
		cc_ctl = '0;
		branch_cond = crcc_pkg::BR_HALF_CARRY;
		repeat (6) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk("cc reset", 8'he8, cc);
		chk("level reset", 8'h03, {6'h00, prio_level});
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(crcc_pkg::SEL_CC, pl[i]);
			chk("cc readback", pl[i] | 8'hc0, cc);
			chk("level", {6'h00, 2'(i)}, {6'h00, prio_level});
			chk("irq off", {7'h00, i == 3}, {7'h00, irq_disabled});
		end
		$display("test levels done");
		alu(crcc_pkg::OP_ADD, 8'h0b, 8'h05, 1'b0, 8'h10, 4'h8, 4'hf);
		alu(crcc_pkg::OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 4'hb, 4'hf);
		alu(crcc_pkg::OP_ADD, 8'h12, 8'h34, 1'b1, 8'h46, 4'h0, 4'hf);
		alu(crcc_pkg::OP_ADC, 8'h70, 8'h0f, 1'b1, 8'h80, 4'hc, 4'hf);
		alu(crcc_pkg::OP_SUB, 8'h01, 8'h02, 1'b0, 8'hff, 4'h5, 4'h7);
		alu(crcc_pkg::OP_SBC, 8'h05, 8'h04, 1'b1, 8'h00, 4'h2, 4'h7);
		alu(crcc_pkg::OP_AND, 8'hf0, 8'h0f, 1'b1, 8'h00, 4'h3, 4'h7);
		alu(crcc_pkg::OP_OR, 8'h80, 8'h01, 1'b0, 8'h81, 4'h4, 4'h7);
		alu(crcc_pkg::OP_XOR, 8'h5a, 8'h5a, 1'b0, 8'h00, 4'h2, 4'h7);
		alu(crcc_pkg::OP_LD, 8'h00, 8'h9c, 1'b0, 8'h9c, 4'h4, 4'h7);
		alu(crcc_pkg::OP_SLL, 8'h81, 8'h00, 1'b0, 8'h02, 4'h1, 4'h7);
		alu(crcc_pkg::OP_SRL, 8'h01, 8'h00, 1'b0, 8'h00, 4'h3, 4'h7);
		alu(crcc_pkg::OP_RLC, 8'h80, 8'h00, 1'b1, 8'h01, 4'h1, 4'h7);
		alu(crcc_pkg::OP_RRC, 8'h01, 8'h00, 1'b1, 8'h80, 4'h5, 4'h7);
		$display("test alu done");
		wr(crcc_pkg::SEL_CC, 8'hc0);
		for (int i = 0; i < 10; i++) begin
			ctl(cv[i]);
			chk("cc control", ev[i], cc);
		end
		for (int k = 0; k < 2; k++) begin
			wr(crcc_pkg::SEL_CC, (k == 0) ? 8'h17 : 8'h00);
			for (int c = 0; c < 8; c++) begin
				branch_cond = crcc_pkg::crcc_br_t'(c[2:0]);
				tick();
				chk("branch", {7'h00, (k == 0) ^ c[0]}, {7'h00, branch_taken});
			end
		end
		$display("test flags done");
		wr(crcc_pkg::SEL_ACC, 8'h5a);
		wr(crcc_pkg::SEL_X, 8'h3c);
		wr(crcc_pkg::SEL_Y, 8'h99);
		wr(crcc_pkg::SEL_CC, 8'h00);
		ip_addr = 16'h1234;
		ip_load = 1'b1;
		tick();
		ip_load = 1'b0;
		tick();
		chk("x", 8'h3c, regs.idx_x);
		chk("ptr high", 8'h12, regs.instr_pointer_high);
		irq_vector = 16'habcd;
		software_priority_regs = 2'b01;
		irq_entry = 1'b1;
		tick();
		irq_entry = 1'b0;
		chk("busy", 8'h01, {7'h00, busy});
		n = 0;
		repeat (7) begin
			@(negedge mclk);
			if (stk_push === 1'b1) begin
				chk("push byte", ex[n & 7], stk_wdata);
				n++;
			end
		end
		chk("push count", 8'h05, n[7:0]);
		tick();
		wait_idle();
		chk("vector low", 8'hcd, regs.instr_pointer_low);
		chk("entry cc", 8'hc8, cc);
		chk("y kept", 8'h99, regs.idx_y);
		ip_inc = 1'b1;
		tick();
		ip_inc = 1'b0;
		tick();
		chk("ptr step", 8'hce, regs.instr_pointer_low);
		wr(crcc_pkg::SEL_ACC, 8'h00);
		wr(crcc_pkg::SEL_CC, 8'h28);
		irq_return_instr = 1'b1;
		tick();
		irq_return_instr = 1'b0;
		n = 0;
		repeat (8) begin
			@(negedge mclk);
			if (stk_pop === 1'b1) n++;
		end
		chk("pop count", 8'h05, n[7:0]);
		tick();
		wait_idle();
		chk("acc back", 8'h5a, regs.acc);
		chk("x back", 8'h3c, regs.idx_x);
		chk("cc back", 8'hc0, cc);
		chk("ptr high back", 8'h12, regs.instr_pointer_high);
		chk("ptr low back", 8'h34, regs.instr_pointer_low);
		chk("y after", 8'h99, regs.idx_y);
		alu_req = '{1'b1, crcc_pkg::OP_SUB, crcc_pkg::SEL_X, 1'b1, 8'h3c};
		tick();
		alu_req.valid = 1'b0;
		tick();
		chk("compare x", 8'h3c, regs.idx_x);
		chk("compare cc", 8'hc2, cc);
		$display("test context done");
		report_and_stop();
	end
endmodule // tb_top
